// [design/aux_port_map.vh]
// Register map and constants for the auxiliary three-pin port
`ifndef AUX_PORT_MAP_VH
`define AUX_PORT_MAP_VH
`define APC_CTRL_IDX       8'h89
`define APC_DATA_IDX       8'h80
`define APC_ISTAT_IDX      8'h84
`define APC_IMASK_IDX      8'h88
`define APC_CTRL_ADDR      10'h224
`define APC_DATA_ADDR      10'h200
`define APC_ISTAT_ADDR     10'h210
`define APC_IMASK_ADDR     10'h220
`define APC_CTRL_RESET     8'h07
`define APC_BIT_IWF        7
`define APC_BIT_OWF        6
`define APC_BIT_OVF        5
`define APC_BIT_PSP        4
`define APC_DIR_MSB        2
`define APC_WMASK          8'h37
`define APC_RESP_OKAY      2'h0
`define APC_RESP_SLVERR    2'h2
`endif

// [design/apc_aux_port.v]
// Auxiliary three-pin port with slave-port status, AXI4-Lite registers
`timescale 1ns/1ps
`include "aux_port_map.vh"
module apc_aux_port #(
    parameter ADDR_W = 10,
    parameter PIN_N  = 3
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write
    input  wire [ADDR_W-1:0] s_awaddr,
    input  wire        s_awvalid,
    output reg         s_awready,
    input  wire [31:0] s_wdata,
    input  wire [3:0]  s_wstrb,
    input  wire        s_wvalid,
    output reg         s_wready,
    output reg  [1:0]  s_bresp,
    output reg         s_bvalid,
    input  wire        s_bready,
    // AXI4-Lite read
    input  wire [ADDR_W-1:0] s_araddr,
    input  wire        s_arvalid,
    output reg         s_arready,
    output reg  [31:0] s_rdata,
    output reg  [1:0]  s_rresp,
    output reg         s_rvalid,
    input  wire        s_rready,
    // Port pins: bit 2 chip select, bit 1 write strobe, bit 0 read strobe
    input  wire [2:0]  aux_port_in,
    output reg  [2:0]  aux_port_out,
    output reg  [2:0]  aux_port_oe_n,
    // Slave-port strobes, active low, decoded from the pins
    output reg         psp_wr_n,
    output reg         psp_rd_n,
    // Internal side of the slave port buffers
    input  wire        core_read_in,
    input  wire        core_write_out,
    // Interrupt
    output reg         irq
);
    reg  [7:0] ctrl_ff;
    reg  [2:0] pout_ff;
    reg        iwf_ff;
    reg        owf_ff;
    reg        ovf_ff;
    reg  [2:0] istat_ff;
    reg  [2:0] imask_ff;
    reg  [2:0] pin_q_ff;
    reg        aw_ok_ff;
    reg        w_ok_ff;
    reg  [ADDR_W-1:0] aw_ff;
    reg  [31:0] wd_ff;
    reg  [3:0] ws_ff;

    wire       psp_mode = ctrl_ff[`APC_BIT_PSP];
    wire [2:0] dir      = ctrl_ff[`APC_DIR_MSB:0];
    wire       sel_n    = aux_port_in[2];
    wire       wr_n     = aux_port_in[1];
    wire       rd_n     = aux_port_in[0];
    wire       pwr_act  = psp_mode & ~sel_n & ~wr_n;
    wire       prd_act  = psp_mode & ~sel_n & ~rd_n;
    reg  [2:0] pin_q_prev_ff;
    // Strobes act on their trailing (rising) edge, as a parallel slave
    // port does; select comes from the sample before that edge, since
    // the host may lift select and strobe in the same cycle
    wire       ext_wr   = psp_mode & ~pin_q_prev_ff[2] &
                          ~pin_q_prev_ff[1] & pin_q_ff[1];
    wire       ext_rd   = psp_mode & ~pin_q_prev_ff[2] &
                          ~pin_q_prev_ff[0] & pin_q_ff[0];
    // A write onto an unread word, unless the core empties it now
    wire       ext_ovf  = ext_wr & iwf_ff & ~core_read_in;

    // Only byte lane 0 carries data; upper bits read as zero.
    // Registers sit at word index times four, so the odd control
    // index still lands on an aligned word. Unaligned or unmapped
    // addresses answer SLVERR and change nothing.
    // One write and one read may be in flight; the readys stay low
    // until the response is taken, so a second request stalls until then.

    // Register selects
    localparam [2:0] SEL_NONE  = 3'h0;
    localparam [2:0] SEL_CTRL  = 3'h1;
    localparam [2:0] SEL_DATA  = 3'h2;
    localparam [2:0] SEL_ISTAT = 3'h3;
    localparam [2:0] SEL_IMASK = 3'h4;

    // Word index decode, shared by the write and read channels
    function [2:0] reg_dec;
        input [ADDR_W-1:0] a;
        begin
            if (a[1:0] != 2'h0) begin
                reg_dec = SEL_NONE;
            end else begin
                case (a[ADDR_W-1:2])
                    `APC_CTRL_IDX:  reg_dec = SEL_CTRL;
                    `APC_DATA_IDX:  reg_dec = SEL_DATA;
                    `APC_ISTAT_IDX: reg_dec = SEL_ISTAT;
                    `APC_IMASK_IDX: reg_dec = SEL_IMASK;
                    default:        reg_dec = SEL_NONE;
                endcase
            end
        end
    endfunction

    // Control register as software sees it; bit 3 is not implemented
    function [7:0] ctrl_view;
        input [7:0] c;
        input       iwf;
        input       owf;
        input       ovf;
        begin
            ctrl_view = {iwf, owf, ovf, c[`APC_BIT_PSP], 1'b0,
                         c[`APC_DIR_MSB:0]};
        end
    endfunction

    wire [2:0] aw_sel   = reg_dec(aw_ff);
    wire [2:0] ar_sel   = reg_dec(s_araddr);
    wire       do_wr    = aw_ok_ff & w_ok_ff & ~s_bvalid;
    wire       wr_ctrl  = do_wr & (aw_sel == SEL_CTRL) & ws_ff[0];
    wire       wr_data  = do_wr & (aw_sel == SEL_DATA) & ws_ff[0];
    wire       wr_ist   = do_wr & (aw_sel == SEL_ISTAT) & ws_ff[0];
    wire       wr_imk   = do_wr & (aw_sel == SEL_IMASK) & ws_ff[0];

    // Next values of the slave-port flags
    reg        nxt_iwf;
    reg        nxt_owf;
    reg        nxt_ovf;
    always @* begin
        nxt_iwf = iwf_ff;
        nxt_owf = owf_ff;
        nxt_ovf = ovf_ff;
        // Set wins over the core's read in the same cycle
        if (ext_wr) begin
            nxt_iwf = 1'b1;
        end else if (core_read_in) begin
            nxt_iwf = 1'b0;
        end
        // A fresh word wins over the host reading the old one
        if (core_write_out) begin
            nxt_owf = 1'b1;
        end else if (ext_rd) begin
            nxt_owf = 1'b0;
        end
        // Overflow only clears by software; a new event wins
        if (ext_ovf) begin
            nxt_ovf = 1'b1;
        end else if (wr_ctrl) begin
            nxt_ovf = wd_ff[`APC_BIT_OVF];
        end
    end

    // Per-pin enable; slave mode forces every pin to an input
    wire [PIN_N-1:0] nxt_oe_n;
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_pin
            assign nxt_oe_n[gi] = psp_mode | dir[gi];
        end
    endgenerate

    // Interrupt status: a new event wins over a software clear
    wire [2:0] ist_evt = {ext_ovf, ext_rd, ext_wr};
    wire [2:0] nxt_istat;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ist
            assign nxt_istat[gi] = ist_evt[gi] |
                                   (istat_ff[gi] & ~(wr_ist & wd_ff[gi]));
        end
    endgenerate

    // Pin sampling; ext_wr and ext_rd look at the sampled copies, while psp_wr_n and psp_rd_n decode the raw pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_q_ff      <= 3'h7;
            pin_q_prev_ff <= 3'h7;
        end else begin
            pin_q_ff      <= aux_port_in;
            pin_q_prev_ff <= pin_q_ff;
        end
    end

    // Pin drivers; slave mode forces all pins to inputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            aux_port_out  <= 3'h0;
            aux_port_oe_n <= 3'h7;
            psp_wr_n      <= 1'b1;
            psp_rd_n      <= 1'b1;
        end else begin
            aux_port_out  <= pout_ff;
            aux_port_oe_n <= nxt_oe_n;
            psp_wr_n      <= ~pwr_act;
            psp_rd_n      <= ~prd_act;
        end
    end

    // Control register and buffer flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `APC_CTRL_RESET;
            pout_ff <= 3'h0;
            iwf_ff  <= 1'b0;
            owf_ff  <= 1'b0;
            ovf_ff  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= wd_ff[7:0] & `APC_WMASK;
            end
            if (wr_data) begin
                pout_ff <= wd_ff[2:0];
            end
            iwf_ff <= nxt_iwf;
            owf_ff <= nxt_owf;
            ovf_ff <= nxt_ovf;
        end
    end

    // Interrupt status: 0 input full, 1 output read, 2 overflow
    always @(posedge aclk) begin
        if (!aresetn) begin
            istat_ff <= 3'h0;
            imask_ff <= 3'h0;
            irq      <= 1'b0;
        end else begin
            istat_ff <= nxt_istat;
            if (wr_imk) begin
                imask_ff <= wd_ff[2:0];
            end
            irq <= |(istat_ff & imask_ff);
        end
    end

    // AXI4-Lite write channel; address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            aw_ff     <= {ADDR_W{1'b0}};
            wd_ff     <= 32'h0000_0000;
            ws_ff     <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `APC_RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_ff     <= s_awaddr;
                aw_ok_ff  <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wd_ff    <= s_wdata;
                ws_ff    <= s_wstrb;
                w_ok_ff  <= 1'b1;
                s_wready <= 1'b0;
            end
            if (do_wr) begin
                s_bvalid <= 1'b1;
                // Unmapped writes are answered but store nothing
                s_bresp  <= (aw_sel != SEL_NONE) ? `APC_RESP_OKAY
                                                 : `APC_RESP_SLVERR;
                aw_ok_ff <= 1'b0;
                w_ok_ff  <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `APC_RESP_OKAY;
        end else begin
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rresp   <= (ar_sel != SEL_NONE) ? `APC_RESP_OKAY
                                                  : `APC_RESP_SLVERR;
                // Data reads return the sampled pins, not the latch
                case (ar_sel)
                    SEL_CTRL:  s_rdata <= {24'h0,
                                   ctrl_view(ctrl_ff, iwf_ff, owf_ff,
                                             ovf_ff)};
                    SEL_DATA:  s_rdata <= {29'h0, pin_q_ff};
                    SEL_ISTAT: s_rdata <= {29'h0, istat_ff};
                    SEL_IMASK: s_rdata <= {29'h0, imask_ff};
                    default:   s_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule

// [tb/apc_aux_port_sva.sv]
// Port-level assertions for the auxiliary three-pin port
`timescale 1ns/1ps
module apc_aux_port_sva (
    // Clock, reset and bus handshakes
    input logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready,
    input logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready,
    // Pins and decoded strobes
    input logic [2:0] aux_port_in, aux_port_oe_n,
    input logic psp_wr_n, psp_rd_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_DIR: assert property (
        $rose(aresetn) |-> aux_port_oe_n == 3'h7) else $error("reset dir");
    AST_WR_STB: assert property (
        !psp_wr_n |-> $past(aux_port_in[2:1]) == 2'h0) else $error("wr");
    AST_RD_STB: assert property (
        !psp_rd_n |-> !$past(aux_port_in[2]) && !$past(aux_port_in[0]))
        else $error("rd");
    AST_STB_IN: assert property (
        !(psp_wr_n && psp_rd_n) |-> aux_port_oe_n == 3'h7) else $error("oe");
    AST_B_HOLD: assert property (
        s_bvalid && !s_bready |=> s_bvalid) else $error("bvalid");
    AST_R_HOLD: assert property (
        s_rvalid && !s_rready |=> s_rvalid) else $error("rvalid");
    AST_B_LAT: assert property (
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("b late");
    AST_R_LAT: assert property (
        s_arvalid && s_arready |=> s_rvalid && !s_arready) else $error("r");
endmodule
bind apc_aux_port apc_aux_port_sva u_sva (.*);

// [tb/apc_host_cpu.sv]
// Model of the external processor on the slave-port pins
`timescale 1ns/1ps
module apc_host_cpu (
    // Clock in, chip select and strobes out, idle high
    input  logic       aclk,
    output logic [2:0] pins
);
    initial pins = 3'h7;
    task automatic strobe(input bit w);
        @(posedge aclk) pins <= w ? 3'h1 : 3'h2;
        repeat (3) @(posedge aclk);
        pins <= 3'h7;
        repeat (4) @(posedge aclk);
    endtask
endmodule

// [tb/tb_apc_aux_port.sv]
// Self-checking bench for the auxiliary three-pin port
`timescale 1ns/1ps
`include "aux_port_map.vh"
module tb_apc_aux_port;
    localparam logic [9:0] ctl = `APC_CTRL_ADDR;
    logic aclk = 0, aresetn = 0, core_read_in = 0, core_write_out = 0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0;
    logic [9:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0;
    wire [31:0] s_rdata;
    wire [1:0] s_bresp, s_rresp;
    wire [2:0] aux_port_out, aux_port_oe_n, host_pins, pins;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    wire psp_wr_n, psp_rd_n;
    int n_errors = 0, checks = 0, cycles = 0;
    // Driven pins show the latch; released ones follow the host
    assign pins = aux_port_oe_n & host_pins | ~aux_port_oe_n & aux_port_out;
    apc_aux_port u_apc_aux_port (.*, .s_wstrb(4'hF), .aux_port_in(pins));
    apc_host_cpu u_apc_host_cpu (.aclk, .pins(host_pins));
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk)
        if (++cycles == 3000) begin
            n_errors++;
            finish_test;
        end
    task automatic finish_test;
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One transfer; the read data is compared against d
    task automatic bus(input bit w, input logic [9:0] a,
                       input logic [7:0] d,
                       input logic [1:0] resp = `APC_RESP_OKAY);
        @(posedge aclk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= {24'h0, d};
        {s_awvalid, s_wvalid, s_bready} <= {3{w}};
        {s_arvalid, s_rready} <= {2{!w}};
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 0;
            if (s_wready) s_wvalid <= 0;
            if (s_arready) s_arvalid <= 0;
        end while (!(w ? s_bvalid : s_rvalid));
        {s_bready, s_rready} <= 2'h0;
        chk(w ? s_bresp : s_rresp, resp);
        if (!w) chk(s_rdata, {24'h0, d});
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        bus(0, ctl, `APC_CTRL_RESET);
        chk(aux_port_oe_n, 3'h7);
        bus(1, ctl, 8'hFF);
        bus(0, ctl, 8'h37);
        bus(1, ctl, 8'h02);
        bus(1, `APC_DATA_ADDR, 8'h00);
        chk(aux_port_oe_n, 3'h2);
        bus(0, `APC_DATA_ADDR, 8'h02);
        bus(1, `APC_DATA_ADDR, 8'h07);
        bus(1, `APC_IMASK_ADDR, 8'h07);
        chk(aux_port_out, 3'h7);
        bus(1, ctl, 8'h17);
        u_apc_host_cpu.strobe(1);
        chk(aux_port_oe_n, 3'h7);
        bus(0, ctl, 8'h97);
        u_apc_host_cpu.strobe(1);
        bus(0, ctl, 8'hB7);
        core_read_in <= 1;
        @(posedge aclk) core_read_in <= 0;
        bus(0, ctl, 8'h37);
        bus(1, ctl, 8'h17);
        core_write_out <= 1;
        @(posedge aclk) core_write_out <= 0;
        bus(0, ctl, 8'h57);
        u_apc_host_cpu.strobe(0);
        bus(0, ctl, 8'h17);
        chk(irq, 1);
        bus(1, `APC_IMASK_ADDR, 8'h00);
        bus(0, `APC_ISTAT_ADDR, 8'h07);
        chk(irq, 0);
        bus(1, `APC_ISTAT_ADDR, 8'h07);
        bus(1, `APC_IMASK_ADDR, 8'h07);
        bus(0, `APC_ISTAT_ADDR, 8'h00);
        chk(irq, 0);
        bus(0, 10'h240, 8'h00, `APC_RESP_SLVERR);
        finish_test;
    end
endmodule
